// ==== rtl/asc_cfg.svh ====
// Purpose: Offsets, reset values and timing counts of the async serial channel
// Assumes: Included by bare name from the channel's design file
// Notes: Byte offsets on the register bus, one aligned word per register
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH
`define ASC_OFF_MODE 8'h00
`define ASC_OFF_RATE 8'h04
`define ASC_OFF_CTRL 8'h08
`define ASC_OFF_TXH 8'h0C
`define ASC_OFF_STAT 8'h10
`define ASC_OFF_RXH 8'h14
`define ASC_RST_MODE 8'h00
`define ASC_RST_CTRL 8'h00
`define ASC_RST_RATE 8'hFF
`define ASC_RST_STAT 8'h80
`define ASC_RST_DATA 8'hFF
`define ASC_STAT_LSB 3
`define ASC_PH_LAST 4'hF
`define ASC_PH_MID 4'h7
`define ASC_PH_SCK 4'h8
`define ASC_BIT_LAST8 3'h7
`define ASC_BIT_LAST7 3'h6
`define ASC_PRE_DIV1 6'h00
`define ASC_PRE_DIV4 6'h03
`define ASC_PRE_DIV16 6'h0F
`define ASC_PRE_DIV64 6'h3F
`define ASC_QUART_LAST 2'h3
`endif

// ==== rtl/asc_pkg.sv ====
// Purpose: Types shared by the async serial channel
// Assumes: Offsets and counts live in asc_cfg.svh
// Notes: Field order of each struct is its bit order in the register
package asc_pkg;
  typedef struct packed {
    logic sync_sel;
    logic char_length_select;
    logic parity_enable;
    logic parity_odd;
    logic stop_two;
    logic spare;
    logic prescale_hi;
    logic prescale_lo;
  } asc_mode_t;
  typedef struct packed {
    logic tx_irq_on;
    logic rx_irq_on;
    logic tx_on;
    logic rx_on;
    logic [1:0] spare;
    logic clock_source_hi;
    logic clock_source_lo;
  } asc_ctrl_t;
  typedef enum logic [2:0] {
    fr_idle = 3'h0,
    fr_start = 3'h1,
    fr_data = 3'h3,
    fr_par = 3'h2,
    fr_stop = 3'h6
  } asc_frame_t;
endpackage : asc_pkg

// ==== rtl/asc_serial_channel.sv ====
// Purpose: One asynchronous serial channel with an AHB-Lite register slave
// Assumes: sys_clk 100 MHz, reset_n synchronous active low, zero-wait bus
// Notes: Notes on behaviour
//
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
`include "asc_cfg.svh"

module asc_serial_channel (
  input wire logic sys_clk, // System clock
  input wire logic reset_n, // Synchronous reset
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Word only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic [31:0] hrdata, // Read data
  output logic hresp, // Always OKAY
  input wire logic xfer_rx_rd, // Transfer controller read of rx holding
  output logic [7:0] rx_char, // Receive holding contents
  input wire logic rxd, // Receive line pin
  output logic txd, // Transmit line pin
  output logic txd_oe, // Transmit line driven
  input wire logic sck_in, // Serial clock pin in
  output logic sck_out, // Serial clock pin out
  output logic sck_oe, // Serial clock pin driven
  output logic tx_empty_irq, // Transmit-empty request
  output logic rx_full_irq, // Receive-full request
  output logic rx_err_irq // Receive-error request
);
  asc_pkg::asc_mode_t mode_q;
  asc_pkg::asc_ctrl_t ctrl_q;
  asc_pkg::asc_frame_t tx_st_q;
  asc_pkg::asc_frame_t rx_st_q;
  logic [7:0] rate_q;
  logic [7:0] tx_hold_q;
  logic [7:0] rx_hold_q;
  logic [4:0] flag_q; // 4 tx_empty, 3 rx_full, 2 overrun, 1 framing, 0 parity
  logic [4:0] seen_q;
  logic [4:0] flag_set;
  logic [4:0] flag_clr;
  logic ph_wr_q;
  logic [7:0] ph_addr_q;
  logic hready_q;
  logic [31:0] hrdata_q;
  logic [5:0] pre_cnt_q;
  logic [7:0] div_cnt_q;
  logic [1:0] quart_q;
  logic sck_s1_q, sck_s2_q, sck_s3_q, sck_f_q;
  logic rx_s1_q, rx_s2_q, rx_s3_q, rx_f_q;
  logic tx_on_q, tx_ones_q, tx_par_q;
  logic [3:0] tx_ph_q;
  logic [2:0] tx_bit_q;
  logic [7:0] tx_sh_q;
  logic [3:0] rx_ph_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic rx_pbit_q;
  logic txd_q, txd_oe_q, sck_out_q, sck_oe_q;
  logic txi_q, rxi_q, eri_q;

  // Bus decode; the slave never stalls, so hready is ours too
  wire addr_ok = hsel & hready & htrans[1];
  wire rd_stat = addr_ok & ~hwrite & (haddr[7:0] == `ASC_OFF_STAT);
  wire wr_mode = ph_wr_q & (ph_addr_q == `ASC_OFF_MODE);
  wire wr_rate = ph_wr_q & (ph_addr_q == `ASC_OFF_RATE);
  wire wr_ctrl = ph_wr_q & (ph_addr_q == `ASC_OFF_CTRL);
  wire wr_txh = ph_wr_q & (ph_addr_q == `ASC_OFF_TXH);
  wire wr_stat = ph_wr_q & (ph_addr_q == `ASC_OFF_STAT);
  wire [7:0] stat_byte = {flag_q, 3'h0};
  wire [7:0] rd_byte = (haddr[7:0] == `ASC_OFF_MODE) ? mode_q :
                       (haddr[7:0] == `ASC_OFF_RATE) ? rate_q :
                       (haddr[7:0] == `ASC_OFF_CTRL) ? ctrl_q :
                       (haddr[7:0] == `ASC_OFF_TXH) ? tx_hold_q :
                       (haddr[7:0] == `ASC_OFF_STAT) ? stat_byte :
                       (haddr[7:0] == `ASC_OFF_RXH) ? rx_hold_q : 8'h00;

  // Address phase is captured; write data lands one cycle later
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ph_wr_q <= 1'b0;
      ph_addr_q <= 8'h00;
      hready_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      ph_wr_q <= addr_ok & hwrite;
      ph_addr_q <= haddr[7:0];
      hready_q <= 1'b1;
      hrdata_q <= (addr_ok & ~hwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // Software registers; reserved bits are forced to zero on write
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mode_q <= asc_pkg::asc_mode_t'(`ASC_RST_MODE);
      ctrl_q <= asc_pkg::asc_ctrl_t'(`ASC_RST_CTRL);
      rate_q <= `ASC_RST_RATE;
      tx_hold_q <= `ASC_RST_DATA;
    end else begin
      if (wr_mode)
        mode_q <= asc_pkg::asc_mode_t'({hwdata[7:3], 1'b0, hwdata[1:0]});
      if (wr_ctrl)
        ctrl_q <= asc_pkg::asc_ctrl_t'({hwdata[7:4], 2'b00, hwdata[1:0]});
      if (wr_rate)
        rate_q <= hwdata[7:0];
      if (wr_txh)
        tx_hold_q <= hwdata[7:0];
    end
  end

  // Prescaler and divisor; a final divide by four yields the 16x tick
  wire [5:0] pre_lim = mode_q.prescale_hi ?
                       (mode_q.prescale_lo ? `ASC_PRE_DIV64 : `ASC_PRE_DIV16) :
                       (mode_q.prescale_lo ? `ASC_PRE_DIV4 : `ASC_PRE_DIV1);
  wire pre_tick = (pre_cnt_q == pre_lim);
  wire div_tick = pre_tick & (div_cnt_q == rate_q);
  wire int_tick = div_tick & (quart_q == `ASC_QUART_LAST);
  wire ext_tick = (sck_s2_q == sck_s3_q) & sck_s3_q & ~sck_f_q;
  wire tick16 = ctrl_q.clock_source_hi ? ext_tick : int_tick;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pre_cnt_q <= 6'h00;
      div_cnt_q <= 8'h00;
      quart_q <= 2'h0;
    end else begin
      pre_cnt_q <= pre_tick ? 6'h00 : pre_cnt_q + 6'h01;
      if (pre_tick)
        div_cnt_q <= (div_cnt_q == rate_q) ? 8'h00 : div_cnt_q + 8'h01;
      if (div_tick)
        quart_q <= quart_q + 2'h1;
    end
  end

  // Pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      {sck_s1_q, sck_s2_q, sck_s3_q, sck_f_q} <= 4'h0;
      {rx_s1_q, rx_s2_q, rx_s3_q, rx_f_q} <= 4'hF;
    end else begin
      sck_s1_q <= sck_in;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      rx_s1_q <= rxd;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      if (sck_s2_q == sck_s3_q)
        sck_f_q <= sck_s3_q;
      if (rx_s2_q == rx_s3_q)
        rx_f_q <= rx_s3_q;
    end
  end

  // Transmitter: a bit lasts 16 ticks; loads happen only on bit edges
  wire [2:0] bit_last = mode_q.char_length_select ? `ASC_BIT_LAST7 : `ASC_BIT_LAST8;
  wire tx_rise = ctrl_q.tx_on & ~tx_on_q;
  wire tx_end = tick16 & (tx_ph_q == `ASC_PH_LAST);
  wire tx_last_stop = ~mode_q.stop_two | tx_bit_q[0];
  wire tx_free = (tx_st_q == asc_pkg::fr_idle) | ((tx_st_q == asc_pkg::fr_stop) & tx_last_stop);
  wire tx_load = ctrl_q.tx_on & ~tx_rise & tx_end & tx_free & ~flag_q[4];
  wire [7:0] tx_mask = mode_q.char_length_select ? 8'h7F : 8'hFF;
  wire tx_line = (tx_st_q == asc_pkg::fr_start) ? 1'b0 :
                 (tx_st_q == asc_pkg::fr_data) ? tx_sh_q[tx_bit_q] :
                 (tx_st_q == asc_pkg::fr_par) ? tx_par_q : 1'b1;

  always_ff @(posedge sys_clk) begin
    if (!reset_n)
      tx_on_q <= 1'b0;
    else
      tx_on_q <= ctrl_q.tx_on;
  end

  // Frame sequencer; a disabled transmitter sits idle with a cleared phase
  always_ff @(posedge sys_clk) begin
    if (!reset_n || !ctrl_q.tx_on) begin
      tx_st_q <= asc_pkg::fr_idle;
      tx_ph_q <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_ones_q <= 1'b0;
    end else if (tx_rise) begin
      tx_st_q <= asc_pkg::fr_start;
      tx_ones_q <= 1'b1;
      tx_ph_q <= 4'h0;
      tx_bit_q <= 3'h0;
    end else begin
      if (tick16)
        tx_ph_q <= tx_ph_q + 4'h1;
      if (tx_end) begin
        unique case (tx_st_q)
          asc_pkg::fr_idle: begin
            if (tx_load)
              tx_st_q <= asc_pkg::fr_start;
          end
          asc_pkg::fr_start: begin
            tx_st_q <= asc_pkg::fr_data;
            tx_bit_q <= 3'h0;
          end
          asc_pkg::fr_data: begin
            if (tx_bit_q == bit_last) begin
              tx_st_q <= mode_q.parity_enable ? asc_pkg::fr_par : asc_pkg::fr_stop;
              tx_bit_q <= 3'h0;
            end else begin
              tx_bit_q <= tx_bit_q + 3'h1;
            end
          end
          asc_pkg::fr_par: begin
            tx_st_q <= asc_pkg::fr_stop;
            tx_bit_q <= 3'h0;
          end
          asc_pkg::fr_stop: begin
            if (!tx_last_stop) begin
              tx_bit_q <= 3'h1;
            end else begin
              tx_st_q <= tx_load ? asc_pkg::fr_start : asc_pkg::fr_idle;
              tx_ones_q <= 1'b0;
            end
          end
          default: tx_st_q <= asc_pkg::fr_idle;
        endcase
      end
    end
  end

  // Shift register and parity are fixed at load time
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      tx_sh_q <= `ASC_RST_DATA;
      tx_par_q <= 1'b1;
    end else if (tx_load) begin
      tx_sh_q <= tx_hold_q;
      tx_par_q <= ^(tx_hold_q & tx_mask) ^ mode_q.parity_odd;
    end
  end

  // Pin drivers; the clock pin is ours only for internal clock output
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      txd_q <= 1'b1;
      txd_oe_q <= 1'b0;
      sck_out_q <= 1'b0;
      sck_oe_q <= 1'b0;
    end else begin
      txd_q <= ~ctrl_q.tx_on | tx_ones_q | tx_rise | tx_line;
      txd_oe_q <= ctrl_q.tx_on;
      sck_out_q <= tx_ph_q[3];
      sck_oe_q <= ~mode_q.sync_sel & ~ctrl_q.clock_source_hi & ctrl_q.clock_source_lo;
    end
  end

  // Receiver: start edge resets the phase, each bit sampled on tick eight
  wire rx_fall = (rx_s2_q == rx_s3_q) & ~rx_s3_q & rx_f_q;
  wire rx_smp = tick16 & (rx_ph_q == `ASC_PH_MID) & (rx_st_q != asc_pkg::fr_idle);
  wire rx_done = rx_smp & (rx_st_q == asc_pkg::fr_stop);
  wire [7:0] rx_word = mode_q.char_length_select ? {1'b0, rx_sh_q[6:0]} : rx_sh_q;
  wire rx_fe = ~rx_f_q;
  wire rx_pe = mode_q.parity_enable & (rx_pbit_q != (^rx_word ^ mode_q.parity_odd));
  wire rx_ovr = flag_q[3];

  always_ff @(posedge sys_clk) begin
    if (!reset_n || !ctrl_q.rx_on) begin
      rx_st_q <= asc_pkg::fr_idle;
      rx_ph_q <= 4'h0;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_pbit_q <= 1'b0;
    end else if (rx_st_q == asc_pkg::fr_idle) begin
      if (rx_fall) begin
        rx_st_q <= asc_pkg::fr_start;
        rx_ph_q <= 4'h0;
        rx_sh_q <= 8'h00;
      end
    end else begin
      if (tick16)
        rx_ph_q <= rx_ph_q + 4'h1;
      if (rx_smp) begin
        unique case (rx_st_q)
          asc_pkg::fr_start: begin
            rx_st_q <= rx_f_q ? asc_pkg::fr_idle : asc_pkg::fr_data;
            rx_bit_q <= 3'h0;
          end
          asc_pkg::fr_data: begin
            rx_sh_q[rx_bit_q] <= rx_f_q;
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == bit_last)
              rx_st_q <= mode_q.parity_enable ? asc_pkg::fr_par : asc_pkg::fr_stop;
          end
          asc_pkg::fr_par: begin
            rx_pbit_q <= rx_f_q;
            rx_st_q <= asc_pkg::fr_stop;
          end
          default: rx_st_q <= asc_pkg::fr_idle;
        endcase
      end
    end
  end

  // Holding register keeps its old word when the frame overruns
  always_ff @(posedge sys_clk) begin
    if (!reset_n)
      rx_hold_q <= 8'h00;
    else if (rx_done && !rx_ovr)
      rx_hold_q <= rx_word;
  end

  // Flag events; a set in the same cycle as a clear wins
  assign flag_set[4] = tx_load;
  assign flag_set[3] = rx_done & ~rx_ovr & ~rx_fe & ~rx_pe;
  assign flag_set[2] = rx_done & rx_ovr;
  assign flag_set[1] = rx_done & rx_fe;
  assign flag_set[0] = rx_done & rx_pe;

  // Per flag: a status read arms it, a later write of zero clears it
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_flag
      assign flag_clr[gi] = (wr_stat & ~hwdata[gi + `ASC_STAT_LSB] & seen_q[gi]) |
                            ((gi == 3) & xfer_rx_rd);
      always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
          flag_q[gi] <= 1'(`ASC_RST_STAT >> (gi + `ASC_STAT_LSB));
          seen_q[gi] <= 1'b0;
        end else begin
          flag_q[gi] <= flag_set[gi] | (flag_q[gi] & ~flag_clr[gi]);
          seen_q[gi] <= (rd_stat & flag_q[gi]) | (seen_q[gi] & ~flag_clr[gi]);
        end
      end
    end
  endgenerate

  // Interrupt requests follow their flags and enables
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      txi_q <= 1'b0;
      rxi_q <= 1'b0;
      eri_q <= 1'b0;
    end else begin
      txi_q <= ctrl_q.tx_irq_on & flag_q[4];
      rxi_q <= ctrl_q.rx_irq_on & flag_q[3];
      eri_q <= ctrl_q.rx_irq_on & (|flag_q[2:0]);
    end
  end

  assign hreadyout = hready_q;
  assign hrdata = hrdata_q;
  assign hresp = 1'b0;
  assign rx_char = rx_hold_q;
  assign txd = txd_q;
  assign txd_oe = txd_oe_q;
  assign sck_out = sck_out_q;
  assign sck_oe = sck_oe_q;
  assign tx_empty_irq = txi_q;
  assign rx_full_irq = rxi_q;
  assign rx_err_irq = eri_q;

  // Checks on the block's own outputs and flags
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_rx_good;
    rx_done && !rx_ovr && !rx_fe && !rx_pe;
  endsequence

  sequence s_rx_over;
    rx_done && rx_ovr;
  endsequence

  tx_off_high_a: assert property (!ctrl_q.tx_on |=> txd_q && !txd_oe_q)
    else $error("transmit line not high while disabled");
  tx_start_low_a: assert property ((tx_st_q == asc_pkg::fr_start) && !tx_ones_q && !tx_rise
    && ctrl_q.tx_on |=> !txd_q)
    else $error("start bit not low");
  tx_load_empty_a: assert property (tx_load |=> flag_q[4] && tx_sh_q == $past(tx_hold_q))
    else $error("load did not set empty flag");
  rx_mid_sample_a: assert property (rx_smp |-> rx_ph_q == 4'h7 && tick16)
    else $error("receive sample off centre");
  rx_full_set_a: assert property (s_rx_good |=> flag_q[3] && rx_hold_q == $past(rx_word))
    else $error("good frame not delivered");
  rx_overrun_a: assert property (s_rx_over |=> flag_q[2] && $stable(rx_hold_q))
    else $error("overrun handled wrongly");
  rx_frame_err_a: assert property (rx_done && rx_fe |=> flag_q[1] && !flag_set[3])
    else $error("framing fault not flagged");
  err_clear_seq_a: assert property (flag_q[2] && !seen_q[2] && !xfer_rx_rd |=> flag_q[2])
    else $error("overrun cleared without status read");
  sck_centre_a: assert property ($rose(sck_out_q) |-> $past(tx_ph_q) == 4'h8)
    else $error("clock output edge off centre");
endmodule : asc_serial_channel

// ==== tb/asc_peer.sv ====
// Purpose: Remote serial peer facing the channel's line pins
// Assumes: One bit lasts BIT system clocks (rate 0, prescale code 0)
// Notes: Line out idles high like a pulled-up mark level
module asc_peer #(
  parameter int BIT = 64
) (
  input wire logic clk, // System clock
  output logic line_out, // Drives the channel's receive pin
  input wire logic line_in // Watches the channel's transmit pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned now = 0;
  int unsigned start_at = 0;
  logic prev = 1'b1;
  initial line_out = 1'b1;

  // Cycle count and last line level, for start-edge detection
  always @(posedge clk) begin
    now <= now + 1;
    prev <= line_in;
  end

  task automatic bit_out(input logic b);
    line_out <= b;
    repeat (BIT) @(posedge clk);
  endtask : bit_out

  // Sends one frame; bad_par and bad_stop break it on purpose
  task automatic send(input logic [7:0] d, input logic [3:0] f, input logic bad_par,
                      input logic bad_stop);
    int nb;
    logic p;
    nb = f[3] ? 7 : 8;
    p = ^(f[3] ? {1'b0, d[6:0]} : d) ^ f[1] ^ bad_par;
    bit_out(1'b0);
    for (int i = 0; i < nb; i++) bit_out(d[i]);
    if (f[2]) bit_out(p);
    bit_out(~bad_stop);
    if (f[0]) bit_out(1'b1);
    bit_out(1'b1);
  endtask : send

  // Decodes one frame, sampling each bit at its centre
  task automatic recv(input logic [3:0] f, output logic [7:0] d, output logic p,
                      output logic stop_ok);
    int nb;
    nb = f[3] ? 7 : 8;
    d = 8'h00;
    p = 1'b0;
    @(posedge clk);
    while (!(prev === 1'b1 && line_in === 1'b0)) @(posedge clk);
    start_at = now;
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      repeat (BIT) @(posedge clk);
      d[i] = line_in;
    end
    if (f[2]) begin
      repeat (BIT) @(posedge clk);
      p = line_in;
    end
    repeat (BIT) @(posedge clk);
    stop_ok = line_in;
  endtask : recv
endmodule : asc_peer

// ==== tb/async_serial_channel_tb_top.sv ====
// Purpose: Self-checking bench of the async serial channel
// Assumes: Zero-wait bus slave; rate 0 and prescale 0 give 64 clocks a bit
// Notes: Format code f is {seven bit, parity on, odd, two stops}
`include "asc_cfg.svh"
module async_serial_channel_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic xfer_rx_rd = 1'b0;
  logic sck_in = 1'b0;
  logic ext_on = 1'b0;
  logic [1:0] sck_cnt = 2'h0;
  logic hreadyout, hresp, rxd, txd, txd_oe, sck_out, sck_oe;
  logic tx_empty_irq, rx_full_irq, rx_err_irq;
  logic [31:0] hrdata;
  logic [7:0] rx_char;
  logic [31:0] rng = 32'h0000_0013;
  int n_fail = 0;
  int tests_run = 0;

  // 100 MHz system clock
  always #5 sys_clk = ~sys_clk;

  // External 16x clock: four system clocks a tick, so a bit is 64 clocks as for the peer
  always @(posedge sys_clk) begin
    sck_cnt <= sck_cnt + 2'h1;
    sck_in <= ext_on & sck_cnt[1];
  end

  asc_serial_channel asc_serial_channel_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .xfer_rx_rd(xfer_rx_rd),
    .rx_char(rx_char), .rxd(rxd), .txd(txd), .txd_oe(txd_oe), .sck_in(sck_in),
    .sck_out(sck_out), .sck_oe(sck_oe), .tx_empty_irq(tx_empty_irq),
    .rx_full_irq(rx_full_irq), .rx_err_irq(rx_err_irq));

  asc_peer #(.BIT(64)) asc_peer_i (.clk(sys_clk), .line_out(rxd), .line_in(txd));

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // One single-word transfer; read data is taken at the data phase's ready edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                     output logic [31:0] rd);
    haddr <= {24'h00_0000, a};
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h00_0000, wd};
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 8'h00, x);
    check(what, x, {24'h00_0000, exp});
    check("hresp", hresp, 0);
  endtask : rd_chk

  // Enables off, format, rate, then one bit of settling time
  task automatic cfg(input logic [3:0] f);
    wr(`ASC_OFF_CTRL, 8'h00);
    wr(`ASC_OFF_MODE, {1'b0, f, 3'h0});
    wr(`ASC_OFF_RATE, 8'h00);
    repeat (64) @(posedge sys_clk);
  endtask : cfg

  // One transmit and one receive in format f, random data
  task automatic fmt_test(input logic [3:0] f);
    logic [31:0] r;
    logic [7:0] d, got, exp_d;
    logic p, ok;
    int unsigned t0;
    int nbits;
    cfg(f);
    r = xs();
    d = r[7:0];
    exp_d = f[3] ? {1'b0, d[6:0]} : d;
    nbits = (f[3] ? 9 : 10) + f[2] + f[0];
    t0 = asc_peer_i.now;
    fork
      asc_peer_i.recv(f, got, p, ok);
      begin
        wr(`ASC_OFF_CTRL, 8'hF1);
        wr(`ASC_OFF_TXH, d);
        rd_chk("status before send", `ASC_OFF_STAT, 8'h80);
        check("tx_empty_irq", tx_empty_irq, 1);
        check("txd_oe", txd_oe, 1);
        check("sck_oe", sck_oe, 1);
        wr(`ASC_OFF_STAT, 8'h00);
      end
    join
    check("idle frame first", 32'(asc_peer_i.start_at - t0 >= nbits * 64), 1);
    check("tx data", got, exp_d);
    if (f[2]) check("tx parity", p, ^exp_d ^ f[1]);
    check("tx stop", ok, 1);
    repeat (128) @(posedge sys_clk);
    check("txd idle", txd, 1);
    r = xs();
    d = r[7:0];
    exp_d = f[3] ? {1'b0, d[6:0]} : d;
    asc_peer_i.send(d, f, 1'b0, 1'b0);
    check("rx_full_irq", rx_full_irq, 1);
    check("rx_char", rx_char, exp_d);
    rd_chk("rx holding", `ASC_OFF_RXH, exp_d);
    rd_chk("status full", `ASC_OFF_STAT, 8'hC0);
    if (f[1]) begin
      xfer_rx_rd <= 1'b1;
      @(posedge sys_clk);
      xfer_rx_rd <= 1'b0;
      @(posedge sys_clk);
    end else begin
      wr(`ASC_OFF_STAT, 8'h80);
    end
    rd_chk("status cleared", `ASC_OFF_STAT, 8'h80);
    check("rx_full_irq off", rx_full_irq, 0);
    $display("test format %h done", f);
  endtask : fmt_test

  // Main sequence
  initial begin
    logic [31:0] r;
    logic [7:0] d, d2;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd_chk("mode reset", `ASC_OFF_MODE, 8'h00);
    rd_chk("rate reset", `ASC_OFF_RATE, 8'hFF);
    rd_chk("ctrl reset", `ASC_OFF_CTRL, 8'h00);
    rd_chk("status reset", `ASC_OFF_STAT, 8'h80);
    rd_chk("rx holding reset", `ASC_OFF_RXH, 8'h00);
    wr(8'h18, 8'hA5);
    rd_chk("unmapped", 8'h18, 8'h00);
    check("txd off", txd, 1);
    $display("test reset done");
    for (int i = 0; i < 16; i++) fmt_test(4'(i));
    cfg(4'h4);
    wr(`ASC_OFF_CTRL, 8'hF1);
    for (int k = 1; k < 4; k++) begin
      r = xs();
      d = r[7:0];
      asc_peer_i.send(d, 4'h4, k[0], k[1]);
      check("rx_err_irq", rx_err_irq, 1);
      check("rx_char on error", rx_char, d);
      wr(`ASC_OFF_STAT, 8'h80);
      rd_chk("error flags", `ASC_OFF_STAT, {3'h4, k[1], k[0], 3'h0});
      wr(`ASC_OFF_STAT, 8'h80);
      rd_chk("error cleared", `ASC_OFF_STAT, 8'h80);
    end
    $display("test errors done");
    r = xs();
    d = r[7:0];
    d2 = r[15:8];
    asc_peer_i.send(d, 4'h4, 1'b0, 1'b0);
    asc_peer_i.send(d2, 4'h4, 1'b0, 1'b0);
    rd_chk("overrun status", `ASC_OFF_STAT, 8'hE0);
    rd_chk("overrun keeps", `ASC_OFF_RXH, d);
    wr(`ASC_OFF_STAT, 8'h80);
    rd_chk("overrun cleared", `ASC_OFF_STAT, 8'h80);
    $display("test overrun done");
    // External clock keeps running from before the format change onward
    ext_on <= 1'b1;
    cfg(4'h0);
    wr(`ASC_OFF_CTRL, 8'hD2);
    r = xs();
    d = r[7:0];
    asc_peer_i.send(d, 4'h0, 1'b0, 1'b0);
    check("ext clock rx_char", rx_char, d);
    check("ext clock rx_full_irq", rx_full_irq, 1);
    check("ext clock sck_oe", sck_oe, 0);
    xfer_rx_rd <= 1'b1;
    @(posedge sys_clk);
    xfer_rx_rd <= 1'b0;
    @(posedge sys_clk);
    $display("test external clock done");
    wr(`ASC_OFF_CTRL, 8'h00);
    asc_peer_i.send(d2, 4'h4, 1'b0, 1'b0);
    rd_chk("rx off ignores", `ASC_OFF_STAT, 8'h80);
    check("txd_oe off", txd_oe, 0);
    check("sck_out off", sck_out, 0);
    $display("test disabled done");
    final_report();
  end

  // Watchdog, about twice the expected run length
  initial begin
    repeat (95000) @(posedge sys_clk);
    n_fail++;
    $display("watchdog expired");
    final_report();
  end
endmodule : async_serial_channel_tb_top
